// ### verilog/protect_defs.svh
// offsets, field positions, reset values and timing counts of the protection supervisor
`ifndef PROTECT_DEFS_SVH
`define PROTECT_DEFS_SVH

// apb byte addresses
`define CTRL_ADDR 12'h000
`define STATUS_ADDR 12'h004

// control register fields
`define CTRL_HIGH_SEL_BIT 0
`define CTRL_RESET 32'h0000_0000

// status register fields
`define STAT_SUPPLY_LOW_BIT 0
`define STAT_SUPPLY_HIGH_BIT 1
`define STAT_OVERCURRENT_BIT 2
`define STAT_LOCK_BIT 3
`define STAT_THERMAL_BIT 4
`define STAT_BRAKE_BIT 5
`define STAT_OFF_BIT 6

// timing: times in ms, clock in kHz
`define CLK_KHZ 40000
`define LOCK_TIME_MS 500
`define AUTO_RELEASE_MS 5000
`define LOCK_CYCLES (`LOCK_TIME_MS * `CLK_KHZ)
`define AUTO_RELEASE_CYCLES (`AUTO_RELEASE_MS * `CLK_KHZ)

`endif

// ### verilog/protect_pkg.sv
// types of the protection supervisor
package protect_pkg;

   // synchronous comparator and detector results
   typedef struct packed {
      logic vcc_low_trip;      // vcc at or below 3.55 V
      logic vcc_good;          // vcc at or above 3.75 V
      logic vcc_over_16v;      // overvoltage threshold 1 (16.0 V)
      logic vcc_over_27v;      // overvoltage threshold 2 (27.2 V)
      logic overcurrent_trip;  // current_sense_voltage at or above 0.25 V
      logic temp_over_160;     // junction above 160 C
      logic temp_under_135;    // junction below 135 C
      logic speed_low;         // speed_command_input below 3.0 % or 1.0 V
   } prot_flags_s;

   // host control pins
   typedef struct packed {
      logic sleep;
      logic direction_select;
      logic short_brake_request;
      logic lock_release_mode_select;
      logic hall_positive_input;
      logic hall_negative_input;
   } ctrl_pins_s;

   // override toward the commutation logic
   typedef struct packed {
      logic short_brake;  // upper off, lower on
      logic phases_off;   // every switch off
   } override_s;

   typedef enum logic [1:0] {
      LOCK_RUN = 2'b01,
      LOCK_HELD = 2'b10
   } lock_state_e;

   typedef struct packed {
      lock_state_e lock;
      logic [27:0] cnt;
      logic supply_low_lockout;
      logic supply_high_lockout;
      logic overcurrent_trip;
      logic thermal;
      logic high_sel;
      logic hall_prev;
      logic dir_prev;
      override_s ovr;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } sup_state_s;

endpackage

// ### verilog/motor_driver_protection_supervisor.sv
// protection supervisor: undervoltage, overvoltage, overcurrent, motor lock, thermal
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`include "protect_defs.svh"

module motor_driver_protection_supervisor import protect_pkg::*; #(
   parameter int unsigned LOCK_CYCLES = `LOCK_CYCLES,
   parameter int unsigned AUTO_RELEASE_CYCLES = `AUTO_RELEASE_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // comparator flags and pins
   input wire prot_flags_s flags,
   input wire ctrl_pins_s pins,
   // bridge override
   output override_s ovr
);

   localparam logic [27:0] LOCK_LAST = 28'(LOCK_CYCLES - 1);
   localparam logic [27:0] AUTO_LAST = 28'(AUTO_RELEASE_CYCLES - 1);

   // after reset: drive allowed, lock timer idle, lower overvoltage threshold selected
   localparam sup_state_s RESET_ST = '{
      lock: LOCK_RUN,
      cnt: 28'h0000000,
      supply_low_lockout: 1'b0,
      supply_high_lockout: 1'b0,
      overcurrent_trip: 1'b0,
      thermal: 1'b0,
      high_sel: 1'b0,
      hall_prev: 1'b0,
      dir_prev: 1'b0,
      ovr: '{short_brake: 1'b0, phases_off: 1'b0},
      pready: 1'b0,
      pslverr: 1'b0,
      prdata: 32'h0000_0000
   };

   logic rst_meta;
   logic rst_n;
   sup_state_s st;
   sup_state_s next_st;
   logic hall_now;
   logic hall_fall;
   logic dir_change;
   logic sleep_event;
   logic low_supply_event;
   logic speed_event;
   logic brake_event;
   logic hard_release;
   logic soft_release;
   logic hall_timeout;
   logic auto_done;
   logic setup_ph;
   logic access_ph;
   logic mapped;
   logic ctrl_wr;
   logic [31:0] ctrl_word;
   logic [31:0] status_word;
   logic locked;
   logic brake_cause;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // control image: only the threshold select is stored
   function automatic logic [31:0] ctrl_image(input sup_state_s s);
      logic [31:0] w;
      w = `CTRL_RESET;
      w[`CTRL_HIGH_SEL_BIT] = s.high_sel;
      return w;
   endfunction

   // status image: live protection states and both override legs
   function automatic logic [31:0] status_image(input sup_state_s s);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`STAT_SUPPLY_LOW_BIT] = s.supply_low_lockout;
      w[`STAT_SUPPLY_HIGH_BIT] = s.supply_high_lockout;
      w[`STAT_OVERCURRENT_BIT] = s.overcurrent_trip;
      w[`STAT_LOCK_BIT] = (s.lock == LOCK_HELD);
      w[`STAT_THERMAL_BIT] = s.thermal;
      w[`STAT_BRAKE_BIT] = s.ovr.short_brake;
      w[`STAT_OFF_BIT] = s.ovr.phases_off;
      return w;
   endfunction

   // differential hall comparator: high while positive leg wins
   assign hall_now = pins.hall_positive_input & ~pins.hall_negative_input;
   assign hall_fall = st.hall_prev & ~hall_now;
   assign dir_change = st.dir_prev ^ pins.direction_select;
   assign setup_ph = psel & ~penable;
   // access with pready already high: the only edge at which a write lands
   assign access_ph = psel & penable & st.pready;
   assign mapped = (paddr == `CTRL_ADDR) || (paddr == `STATUS_ADDR);
   assign ctrl_wr = access_ph & pwrite & (paddr == `CTRL_ADDR);

   // release events, one name each
   assign sleep_event = pins.sleep;
   // the comparator counts too, so release does not wait for the lockout flop
   assign low_supply_event = flags.vcc_low_trip | st.supply_low_lockout;
   assign speed_event = flags.speed_low;
   assign brake_event = pins.short_brake_request;
   assign hard_release = sleep_event | low_supply_event;
   // the remaining events only count with the mode pin low
   assign soft_release = ~pins.lock_release_mode_select &
      (hall_fall | speed_event | dir_change | brake_event);
   assign hall_timeout = (st.cnt >= LOCK_LAST);
   assign auto_done = ~pins.lock_release_mode_select & (st.cnt >= AUTO_LAST);

   assign ctrl_word = ctrl_image(st);
   assign status_word = status_image(st);

   always_comb begin
      next_st = st;
      next_st.hall_prev = hall_now;
      next_st.dir_prev = pins.direction_select;

      // apb: one wait-free access phase, answer registered in setup
      next_st.pready = setup_ph;
      next_st.pslverr = setup_ph & ~mapped;
      if (setup_ph && !pwrite) begin
         if (paddr == `CTRL_ADDR) begin
            next_st.prdata = ctrl_word;
         end else if (paddr == `STATUS_ADDR) begin
            next_st.prdata = status_word;
         end else begin
            next_st.prdata = 32'h0000_0000;
         end
      end
      if (ctrl_wr) begin
         next_st.high_sel = pwdata[`CTRL_HIGH_SEL_BIT];
      end

      // undervoltage with hysteresis between the two comparators
      if (flags.vcc_low_trip) begin
         next_st.supply_low_lockout = 1'b1;
      end else if (flags.vcc_good) begin
         next_st.supply_low_lockout = 1'b0;
      end

      // software picks which overvoltage comparator applies
      next_st.supply_high_lockout = st.high_sel ? flags.vcc_over_27v :
         flags.vcc_over_16v;
      next_st.overcurrent_trip = flags.overcurrent_trip;

      if (flags.temp_over_160) begin
         next_st.thermal = 1'b1;
      end else if (flags.temp_under_135) begin
         next_st.thermal = 1'b0;
      end

      // one counter times the hall period in run and the auto release in lock
      unique case (st.lock)
         LOCK_RUN: begin
            if (hard_release || hall_fall) begin
               next_st.cnt = 28'h0000000;
            end else if (hall_timeout) begin
               next_st.lock = LOCK_HELD;
               next_st.cnt = 28'h0000000;
            end else begin
               next_st.cnt = st.cnt + 28'h0000001;
            end
         end
         LOCK_HELD: begin
            if (hard_release || soft_release) begin
               next_st.lock = LOCK_RUN;
               next_st.cnt = 28'h0000000;
            end else if (auto_done) begin
               next_st.lock = LOCK_RUN;
               next_st.cnt = 28'h0000000;
            end else if (!pins.lock_release_mode_select) begin
               next_st.cnt = st.cnt + 28'h0000001;
            end else begin
               // mode high: timer parked so a later mode change restarts it cleanly
               next_st.cnt = 28'h0000000;
            end
         end
         default: begin
            next_st.lock = LOCK_RUN;
            next_st.cnt = 28'h0000000;
         end
      endcase

      locked = (next_st.lock == LOCK_HELD);
      brake_cause = next_st.supply_low_lockout | next_st.supply_high_lockout |
         next_st.overcurrent_trip | locked;
      next_st.ovr.phases_off = next_st.thermal;
      // all-off beats short brake: lower switches must not close while hot
      next_st.ovr.short_brake = ~next_st.thermal & brake_cause;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= RESET_ST;
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign ovr = st.ovr;

endmodule // motor_driver_protection_supervisor

// ### verification/sup_props.sv
// port checker of the protection supervisor
`timescale 1ns/100ps
module sup_props import protect_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // apb handshake
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // protection
   input wire prot_flags_s flags,
   input wire override_s ovr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_uv; flags.vcc_low_trip |=> ovr != 2'b00; endproperty
   a_uv: assert property (p_uv) else $error("no brake on low supply");
   property p_ov; flags.vcc_over_16v && flags.vcc_over_27v |=> ovr != 2'b00; endproperty
   a_ov: assert property (p_ov) else $error("no brake on high supply");
   property p_oc; flags.overcurrent_trip |=> ovr != 2'b00; endproperty
   a_oc: assert property (p_oc) else $error("no brake on overcurrent");
   property p_th; flags.temp_over_160 |=> ovr == 2'b01; endproperty
   a_th: assert property (p_th) else $error("phases not off when hot");
   property p_tk; ovr.phases_off && !flags.temp_under_135 |=> ovr.phases_off; endproperty
   a_tk: assert property (p_tk) else $error("thermal off released early");
   property p_tr; $fell(ovr.phases_off) |-> $past(flags.temp_under_135); endproperty
   a_tr: assert property (p_tr) else $error("thermal release without cooling");
   property p_pr; ovr.phases_off |-> !ovr.short_brake; endproperty
   a_pr: assert property (p_pr) else $error("brake and all off together");
   property p_rd; psel && !penable |=> pready; endproperty
   a_rd: assert property (p_rd) else $error("apb answer late");
   c_sb: cover property (ovr == 2'b10);
   c_off: cover property (ovr == 2'b01);
   c_rd: cover property (psel && penable && pready);
endmodule // sup_props

// ### verification/hall_model.sv
// hall sensor model: differential square wave while the rotor turns
`timescale 1ns/100ps
module hall_model #(
   parameter int HALF = 4
) (
   // clock and control
   input wire logic clk,
   input wire logic spin,
   // differential output
   output logic pos,
   output logic neg
);
   int cnt = 0;
   initial pos = 1'b0;
   assign neg = ~pos;
   // a stalled rotor leaves the magnet where it stopped
   always @(posedge clk) begin
      if (spin) begin
         cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
         if (cnt == HALF - 1) pos <= ~pos;
      end
   end
endmodule // hall_model

// ### verification/motor_driver_protection_supervisor_tb_top.sv
// testbench of the protection supervisor
`timescale 1ns/100ps
module motor_driver_protection_supervisor_tb_top import protect_pkg::*; ;
   localparam int LK = 20;
   localparam int AR = 50;
   logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic pready, pslverr, er, hp, hn, spin = 1'b1;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   prot_flags_s f = '0;
   ctrl_pins_s pn = '0;
   override_s ovr;
   int error_cnt = 0, check_count = 0, n;
   always #12.5 clk = ~clk;
   motor_driver_protection_supervisor #(.LOCK_CYCLES(LK), .AUTO_RELEASE_CYCLES(AR)) dut (
      .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .flags(f), .pins({pn[5:2], hp, hn}), .ovr);
   hall_model #(.HALF(4)) hall (.clk, .spin, .pos(hp), .neg(hn));
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic cmp(input string s, input logic [31:0] v, input logic [31:0] e);
      check_count++;
      if (v !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", s, e, v);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      cyc(1);
      penable <= 1'b1;
      do cyc(1); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      cyc(1);
   endtask
   task automatic lock(input bit early);
      spin <= 1'b0;
      cyc(LK - 9);
      if (early) cmp("early", ovr, 0);
      cyc(21);
      cmp("lock", ovr, 2'b10);
   endtask
   // one release event, then a supply-good pulse and a status read
   task automatic ev(input int i);
      case (i)
         0: pn.sleep <= 1'b1;
         1: f.vcc_low_trip <= 1'b1;
         2: spin <= 1'b1;
         3: f.speed_low <= 1'b1;
         4: pn.direction_select <= ~pn.direction_select;
         default: pn.short_brake_request <= 1'b1;
      endcase
      cyc(i == 2 ? 9 : 1);
      pn.sleep <= 1'b0;
      pn.short_brake_request <= 1'b0;
      spin <= 1'b0;
      f <= 8'h40;
      cyc(1);
      f <= '0;
      apb(0, 12'h004, 0);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      cyc(5000);
      error_cnt++;
      final_report();
   end
   initial begin
      cyc(12);
      arst_n <= 1'b1;
      cyc(3);
      cmp("ovr", ovr, 0);
      apb(0, 12'h000, 0);
      cmp("ctrl", rd, 0);
      apb(0, 12'h004, 0);
      cmp("status", rd, 0);
      apb(1, 12'h008, 1);
      cmp("slverr", er, 1);
      f.vcc_low_trip <= 1'b1;
      cyc(1);
      f.vcc_low_trip <= 1'b0;
      cyc(4);
      cmp("uv hold", ovr, 2'b10);
      f.vcc_good <= 1'b1;
      cyc(2);
      cmp("uv off", ovr, 0);
      f <= 8'h20;
      cyc(2);
      cmp("ov16", ovr, 2'b10);
      apb(1, 12'h000, 1);
      cyc(1);
      cmp("ov27 sel", ovr, 0);
      f.vcc_over_27v <= 1'b1;
      cyc(2);
      cmp("ov27", ovr, 2'b10);
      f <= 8'h08;
      apb(1, 12'h000, 0);
      cmp("overcurrent", ovr, 2'b10);
      f.temp_over_160 <= 1'b1;
      cyc(1);
      f.temp_over_160 <= 1'b0;
      cyc(3);
      cmp("thermal", ovr, 2'b01);
      f.temp_under_135 <= 1'b1;
      cyc(2);
      cmp("cool", ovr, 2'b10);
      f <= '0;
      cyc(2);
      cmp("overcurrent off", ovr, 0);
      $display("test faults done");
      for (int i = 0; i < 6; i++) begin
         lock(i == 0);
         ev(i);
         cmp("release", rd[3], 1'b0);
      end
      spin <= 1'b0;
      n = 0;
      while (ovr !== 2'b10 && n < 99) begin
         cyc(1);
         n++;
      end
      cyc(AR - 4);
      cmp("auto held", ovr, 2'b10);
      cyc(6);
      cmp("auto", ovr, 0);
      pn.lock_release_mode_select <= 1'b1;
      lock(0);
      for (int i = 2; i < 6; i++) begin
         ev(i);
         cmp("held", rd[3], 1'b1);
      end
      cyc(AR);
      cmp("no auto", ovr, 2'b10);
      ev(0);
      cmp("sleep", rd[3], 1'b0);
      lock(0);
      ev(1);
      cmp("supply low release", rd[3], 1'b0);
      $display("test lock done");
      final_report();
   end
endmodule // motor_driver_protection_supervisor_tb_top
bind motor_driver_protection_supervisor sup_props chk (.clk, .arst_n, .psel, .penable,
   .pready, .flags, .ovr);
